// ---- test/tb_csc_regs.sv ----
// bench for the clock synthesizer configuration bank
// assumes a read answers and a write shows one cycle after its request edge
`timescale 1ns/1ps
module tb_csc_regs;
  import csc_pkg::*;
  localparam logic [31:0] REF = 32'h0000_0F00;
  logic clock_i, rst_b_i, ce_i, rvalid_o, mult_valid_o, div_valid_o, clamp, halve;
  logic run, sleep, from_synth;
  csc_req_t req_i;
  logic [7:0] rdata_o, power_ctrl_o;
  logic [5:0] mult_o;
  logic [3:0] div_o, range_o, gain_a, gain_b;
  logic [1:0] gain_o;
  logic [31:0] osc_o;
  int n_mismatch, total_checks, cycles;
  csc_regs #(.REF_FREQ_KHZ(REF)) i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .mult_o(mult_o),
    .mult_valid_o(mult_valid_o), .div_o(div_o), .div_valid_o(div_valid_o),
    .osc_freq_khz_o(osc_o), .loop_filter_clamp_o(clamp), .osc_halve_output_o(halve),
    .synth_gain_o(gain_o), .synth_range_o(range_o), .synth_run_o(run),
    .synth_sleep_o(sleep), .sample_clk_from_synth_o(from_synth),
    .coarse_gain_a_o(gain_a), .coarse_gain_b_o(gain_b), .power_ctrl_o(power_ctrl_o));
  // ----------------------------------------------------------------
  // clock and run limit
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1 req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    #1 req_i.wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    #1 req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    #1 req_i.rd = 1'b0;
    chk({31'h0, rvalid_o}, 32'h1);
    chk({24'h0, rdata_o}, {24'h0, exp});
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [4:0] mc [6];
    logic [2:0] nc [4];
    mc = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F};
    nc = '{3'h0, 3'h1, 3'h3, 3'h7};
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    req_i = '0;
    repeat (2) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    rd(ADDR_POWER_SYNTH_ENABLE, 8'h0D);
    rd(ADDR_DAC_COARSE_GAIN, 8'hFF);
    rd(ADDR_SYNTH_DIVIDER_RATIO, 8'h00);
    rd(ADDR_SYNTH_LOOP_CONTROL, 8'h00);
    chk({gain_a, gain_b}, 32'hFF);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_SYNTH_DIVIDER_RATIO, {mc[i], 3'h0});
      chk({mult_valid_o, 25'h0, mult_o}, 32'h8000_0000 | (32'h1 << i));
      chk(osc_o, REF << i);
    end
    wr(ADDR_SYNTH_DIVIDER_RATIO, 8'h10);
    chk({mult_valid_o, 25'h0, mult_o}, 32'h0);
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_SYNTH_DIVIDER_RATIO, {5'h1F, nc[j]});
      chk({div_valid_o, 27'h0, div_o}, 32'h8000_0000 | (32'h1 << j));
      chk(osc_o, (REF * 32) >> j);
    end
    wr(ADDR_SYNTH_DIVIDER_RATIO, 8'hFA);
    chk({div_valid_o, 27'h0, div_o}, 32'h0);
    rd(ADDR_SYNTH_DIVIDER_RATIO, 8'hFA);
    $display("divider decode done");
    wr(ADDR_SYNTH_LOOP_CONTROL, 8'h80);
    chk({clamp, halve}, 32'h2);
    wr(ADDR_SYNTH_LOOP_CONTROL, 8'h7F);
    chk({clamp, halve, gain_o, range_o}, 32'h7F);
    wr(ADDR_POWER_SYNTH_ENABLE, 8'h03);
    chk({run, sleep, from_synth}, 32'h3);
    wr(ADDR_POWER_SYNTH_ENABLE, 8'hC0);
    chk({run, sleep, from_synth, power_ctrl_o}, 32'hC0);
    wr(ADDR_POWER_SYNTH_ENABLE, 8'h01);
    chk({run, sleep, from_synth}, 32'h5);
    $display("control bits done");
    wr(ADDR_DAC_COARSE_GAIN, 8'h5A);
    chk({gain_a, gain_b}, 32'h5A);
    rd(ADDR_DAC_COARSE_GAIN, 8'h5A);
    wr(ADDR_RESERVED_SLOT, 8'hFF);
    rd(ADDR_RESERVED_SLOT, 8'h00);
    rd(5'h05, 8'h00);
    ce_i = 1'b0;
    wr(ADDR_DAC_COARSE_GAIN, 8'h00);
    ce_i = 1'b1;
    rd(ADDR_DAC_COARSE_GAIN, 8'h5A);
    rst_b_i = 1'b0;
    @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    chk({gain_a, gain_b}, 32'hFF);
    chk({mult_valid_o, 25'h0, mult_o}, 32'h8000_0001);
    chk(osc_o, REF);
    chk({run, sleep, from_synth}, 32'h5);
    $display("gain and reserved done");
    conclude();
  end
endmodule

// ---- verilog/csc_pkg.sv ----
// constants and types of the clock synthesizer configuration bank
// assumes an upstream serial port that delivers single-byte register accesses
// Notes on behaviour
// - multiplier field decodes thermometer: 1,2,4,8,16,32
// - divider field decodes thermometer: 1,2,4,8
// - oscillator frequency equals reference times M over N
// - clamp bit holds loop filter at zero
// - enable bit runs synthesizer, selects its sample clock
// - sleep bit sleeps synthesizer; bypass alone does not
package csc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] ADDR_POWER_SYNTH_ENABLE = 5'h1A;
  localparam logic [4:0] ADDR_DAC_COARSE_GAIN = 5'h1B;
  localparam logic [4:0] ADDR_RESERVED_SLOT = 5'h1C;
  localparam logic [4:0] ADDR_SYNTH_DIVIDER_RATIO = 5'h1D;
  localparam logic [4:0] ADDR_SYNTH_LOOP_CONTROL = 5'h1E;

  localparam logic [7:0] RST_POWER_SYNTH_ENABLE = 8'h0D;
  localparam logic [7:0] RST_DAC_COARSE_GAIN = 8'hFF;
  localparam logic [7:0] RST_RESERVED_SLOT = 8'h00;
  localparam logic [7:0] RST_SYNTH_DIVIDER_RATIO = 8'h00;
  localparam logic [7:0] RST_SYNTH_LOOP_CONTROL = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SYNTH_ENA = 0;
  localparam int BIT_SYNTH_SLEEP = 1;
  localparam int BIT_CLAMP = 7;
  localparam int BIT_HALVE = 6;
  localparam int GAIN_HI = 5;
  localparam int GAIN_LO = 4;
  localparam int RANGE_HI = 3;
  localparam int RANGE_LO = 0;
  localparam int MULT_HI = 7;
  localparam int MULT_LO = 3;
  localparam int DIV_HI = 2;
  localparam int DIV_LO = 0;
  localparam int CGA_HI = 7;
  localparam int CGA_LO = 4;
  localparam int CGB_HI = 3;
  localparam int CGB_LO = 0;

  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam logic [31:0] REF_FREQ_KHZ_DEFAULT = 32'h0001_86A0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } csc_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] power_synth_enable;
    logic [DATA_W-1:0] dac_coarse_gain;
    logic [DATA_W-1:0] synth_divider_ratio;
    logic [DATA_W-1:0] synth_loop_control;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } csc_state_t;

endpackage

// ---- verilog/csc_regs.sv ----
// configuration bank for the clock-multiplying synthesizer and coarse gains
// assumes single-cycle byte accesses from a serial port on the same clock
`timescale 1ns/1ps
module csc_regs #(
  parameter logic [31:0] REF_FREQ_KHZ = csc_pkg::REF_FREQ_KHZ_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire csc_pkg::csc_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [5:0] mult_o,
  output logic mult_valid_o,
  output logic [3:0] div_o,
  output logic div_valid_o,
  output logic [31:0] osc_freq_khz_o,
  output logic loop_filter_clamp_o,
  output logic osc_halve_output_o,
  output logic [1:0] synth_gain_o,
  output logic [3:0] synth_range_o,
  output logic synth_run_o,
  output logic synth_sleep_o,
  output logic sample_clk_from_synth_o,
  output logic [3:0] coarse_gain_a_o,
  output logic [3:0] coarse_gain_b_o,
  output logic [7:0] power_ctrl_o
);
  import csc_pkg::*;

  // ----------------------------------------------------------------
  // thermometer decode
  // ----------------------------------------------------------------
  // returns {valid, number of ones}; value is 2 to that power
  function automatic logic [3:0] therm_decode(input logic [4:0] code);
    logic [2:0] ones;
    ones = 3'h0;
    for (int i = 0; i < 5; i++) begin
      ones = 3'(ones + {2'h0, code[i]});
    end
    therm_decode = {((code & 5'(code + 5'h01)) == 5'h00), ones};
  endfunction

  csc_state_t st;
  csc_state_t next_st;
  logic [3:0] m_dec;
  logic [3:0] n_dec;

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    if (req_i.wr) begin
      case (req_i.addr)
        ADDR_POWER_SYNTH_ENABLE: next_st.power_synth_enable = req_i.wdata;
        ADDR_DAC_COARSE_GAIN: next_st.dac_coarse_gain = req_i.wdata;
        ADDR_SYNTH_DIVIDER_RATIO: next_st.synth_divider_ratio = req_i.wdata;
        ADDR_SYNTH_LOOP_CONTROL: next_st.synth_loop_control = req_i.wdata;
        default: begin
        end
      endcase
    end
    if (req_i.rd) begin
      next_st.rvalid = 1'b1;
      case (req_i.addr)
        ADDR_POWER_SYNTH_ENABLE: next_st.rdata = st.power_synth_enable;
        ADDR_DAC_COARSE_GAIN: next_st.rdata = st.dac_coarse_gain;
        ADDR_RESERVED_SLOT: next_st.rdata = RST_RESERVED_SLOT;
        ADDR_SYNTH_DIVIDER_RATIO: next_st.rdata = st.synth_divider_ratio;
        ADDR_SYNTH_LOOP_CONTROL: next_st.rdata = st.synth_loop_control;
        default: next_st.rdata = RDATA_NONE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.power_synth_enable <= RST_POWER_SYNTH_ENABLE;
      st.dac_coarse_gain <= RST_DAC_COARSE_GAIN;
      st.synth_divider_ratio <= RST_SYNTH_DIVIDER_RATIO;
      st.synth_loop_control <= RST_SYNTH_LOOP_CONTROL;
      st.rdata <= RDATA_NONE;
      st.rvalid <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // synthesizer controls
  // ----------------------------------------------------------------
  assign m_dec = therm_decode(st.synth_divider_ratio[MULT_HI:MULT_LO]);
  assign n_dec = therm_decode({2'h0, st.synth_divider_ratio[DIV_HI:DIV_LO]});
  assign mult_valid_o = m_dec[3];
  assign div_valid_o = n_dec[3];
  assign mult_o = mult_valid_o ? 6'(6'h01 << m_dec[2:0]) : 6'h00;
  assign div_o = div_valid_o ? 4'(4'h1 << n_dec[2:0]) : 4'h0;
  // ratio is a power of two, so shifts give the exact product
  assign osc_freq_khz_o = (mult_valid_o && div_valid_o) ?
    32'((REF_FREQ_KHZ << m_dec[2:0]) >> n_dec[2:0]) : 32'h0000_0000;

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign loop_filter_clamp_o = st.synth_loop_control[BIT_CLAMP];
  assign osc_halve_output_o = st.synth_loop_control[BIT_HALVE];
  assign synth_gain_o = st.synth_loop_control[GAIN_HI:GAIN_LO];
  assign synth_range_o = st.synth_loop_control[RANGE_HI:RANGE_LO];
  assign synth_sleep_o = st.power_synth_enable[BIT_SYNTH_SLEEP];
  // bypass does not force sleep; a sleeping synthesizer simply does not run
  assign synth_run_o = st.power_synth_enable[BIT_SYNTH_ENA] && !synth_sleep_o;
  assign sample_clk_from_synth_o = st.power_synth_enable[BIT_SYNTH_ENA];
  assign coarse_gain_a_o = st.dac_coarse_gain[CGA_HI:CGA_LO];
  assign coarse_gain_b_o = st.dac_coarse_gain[CGB_HI:CGB_LO];
  assign power_ctrl_o = st.power_synth_enable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_wr(logic [4:0] a);
    ce_i && req_i.wr && (req_i.addr == a);
  endsequence

  sequence s_rd(logic [4:0] a);
    ce_i && req_i.rd && (req_i.addr == a);
  endsequence

  a_mult_full: assert property (
    s_wr(ADDR_SYNTH_DIVIDER_RATIO) && req_i.wdata[MULT_HI:MULT_LO] == 5'h1F
    |=> mult_valid_o && mult_o == 6'h20)
    else $error("multiplier 11111 did not give 32");
  a_mult_bad: assert property (
    s_wr(ADDR_SYNTH_DIVIDER_RATIO) && req_i.wdata[MULT_HI:MULT_LO] == 5'h02
    |=> !mult_valid_o && mult_o == 6'h00)
    else $error("multiplier 00010 not flagged invalid");
  a_div_four: assert property (
    s_wr(ADDR_SYNTH_DIVIDER_RATIO) && req_i.wdata[DIV_HI:DIV_LO] == 3'h3
    |=> div_valid_o && div_o == 4'h4)
    else $error("divider 011 did not give 4");
  a_osc_ratio: assert property (
    mult_valid_o && div_valid_o |->
    64'(osc_freq_khz_o) * 64'(div_o) == 64'(REF_FREQ_KHZ) * 64'(mult_o))
    else $error("oscillator frequency not reference times M over N");
  a_clamp_hold: assert property (
    s_wr(ADDR_SYNTH_LOOP_CONTROL) ##1 !(ce_i && req_i.wr) [*2]
    |-> loop_filter_clamp_o == $past(req_i.wdata[BIT_CLAMP], 2))
    else $error("loop filter clamp does not follow its bit");
  a_gain_nibbles: assert property (
    s_wr(ADDR_DAC_COARSE_GAIN) |=>
    {coarse_gain_a_o, coarse_gain_b_o} == $past(req_i.wdata))
    else $error("coarse gain nibbles misplaced");
  a_synth_select: assert property (
    s_wr(ADDR_POWER_SYNTH_ENABLE) && req_i.wdata[BIT_SYNTH_ENA:BIT_SYNTH_ENA] == 1'b1
    && !req_i.wdata[BIT_SYNTH_SLEEP]
    |=> sample_clk_from_synth_o && synth_run_o)
    else $error("enable did not select synthesizer clock");
  a_sleep_indep: assert property (
    s_wr(ADDR_POWER_SYNTH_ENABLE) && !req_i.wdata[BIT_SYNTH_ENA]
    |=> synth_sleep_o == $past(req_i.wdata[BIT_SYNTH_SLEEP]) && !sample_clk_from_synth_o)
    else $error("bypass changed the sleep state");
  a_mult_two: assert property (
    s_wr(ADDR_SYNTH_DIVIDER_RATIO) && req_i.wdata[MULT_HI:MULT_LO] == 5'h01
    |=> mult_valid_o && mult_o == 6'h02)
    else $error("multiplier 00001 did not give 2");
  a_div_bad: assert property (
    s_wr(ADDR_SYNTH_DIVIDER_RATIO) && req_i.wdata[DIV_HI:DIV_LO] == 3'h2
    |=> !div_valid_o && div_o == 4'h0)
    else $error("divider 010 not flagged invalid");
  a_osc_invalid: assert property (
    !(mult_valid_o && div_valid_o) |-> osc_freq_khz_o == 32'h0000_0000)
    else $error("oscillator frequency not zero for invalid ratio");
  a_clamp_release: assert property (
    s_wr(ADDR_SYNTH_LOOP_CONTROL) && !req_i.wdata[BIT_CLAMP]
    |=> !loop_filter_clamp_o)
    else $error("loop filter not released");
  a_loop_fields: assert property (
    s_wr(ADDR_SYNTH_LOOP_CONTROL) |=>
    {loop_filter_clamp_o, osc_halve_output_o, synth_gain_o, synth_range_o}
    == $past(req_i.wdata))
    else $error("loop control fields misplaced");
  a_power_byte: assert property (
    s_wr(ADDR_POWER_SYNTH_ENABLE) |=> power_ctrl_o == $past(req_i.wdata))
    else $error("power control byte not stored");
  a_sleep_sets: assert property (
    s_wr(ADDR_POWER_SYNTH_ENABLE) && req_i.wdata[BIT_SYNTH_SLEEP]
    |=> synth_sleep_o && !synth_run_o)
    else $error("sleep bit did not stop the synthesizer");

  // ----------------------------------------------------------------
  // read path and clock enable checks
  // ----------------------------------------------------------------
  a_read_valid: assert property (
    ce_i && req_i.rd |=> rvalid_o)
    else $error("read not answered one cycle later");
  a_rvalid_once: assert property (
    ce_i && !req_i.rd |=> !rvalid_o)
    else $error("read valid without a read");
  a_gain_readback: assert property (
    s_rd(ADDR_DAC_COARSE_GAIN) |=>
    rdata_o == $past({coarse_gain_a_o, coarse_gain_b_o}))
    else $error("coarse gain read back wrong");
  a_reserved_zero: assert property (
    s_rd(ADDR_RESERVED_SLOT) |=> rdata_o == RST_RESERVED_SLOT)
    else $error("reserved slot read not zero");
  a_ignored_write: assert property (
    s_wr(ADDR_RESERVED_SLOT) |=>
    $stable(power_ctrl_o) && $stable(mult_o) && $stable(synth_range_o)
    && $stable({coarse_gain_a_o, coarse_gain_b_o}))
    else $error("reserved write changed a register");
  a_ce_freeze: assert property (
    !ce_i |=> $stable(power_ctrl_o) && $stable(rdata_o) && $stable(rvalid_o)
    && $stable({coarse_gain_a_o, coarse_gain_b_o}))
    else $error("state changed with clock enable low");

endmodule
